// file: verilog/fps_pkg.sv
// constants, command codes and state types for the flash program/erase status block
package fps_pkg;

  // ==========================================================
  // command words, checked on the low data byte only
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
  localparam logic [7:0] CMD_RESET = 8'hf0;

  // ==========================================================
  // coded-cycle addresses, low twelve address bits only
  localparam int CMD_ADDR_W = 12;
  localparam logic [11:0] ADDR8_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR8_UNLOCK2 = 12'haaa;
  localparam logic [11:0] ADDR16_UNLOCK1 = 12'haaa;
  localparam logic [11:0] ADDR16_UNLOCK2 = 12'h554;

  // ==========================================================
  // status word bit positions
  localparam int POLL_POS = 7;
  localparam int TOGGLE_POS = 6;
  localparam int FAIL_POS = 5;
  localparam int WINDOW_POS = 3;
  localparam logic [15:0] STATUS_ZERO = 16'h0000;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ==========================================================
  // timing, in nanoseconds
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_WINDOW_NS = 100000; // erase_window_time
  localparam int CMD_GAP_NS = 100000;      // longest gap between command writes
  localparam int PROG_TIME_NS = 2000;      // nominal byte/word program time
  localparam int PROG_LIMIT_NS = 20000;    // program internal timeout
  localparam int ERASE_LIMIT_NS = 5000000; // erase internal timeout
  localparam int CNT_W = 20;

  // ==========================================================
  // byte-lane steering modes
  typedef enum logic [1:0] {
    LANE_WORD = 2'h0,  // 16-bit whole words only
    LANE_BHE = 2'h1,   // high_byte_enable_n with A0
    LANE_SPLIT = 2'h2  // split low/high write strobes
  } fps_lane_t;

  // command decoder, gray along the unlock path
  typedef enum logic [2:0] {
    CMD_IDLE = 3'h0,
    CMD_U1 = 3'h1,
    CMD_U2 = 3'h3,
    CMD_PGM = 3'h2,
    CMD_E1 = 3'h6,
    CMD_E2 = 3'h7,
    CMD_E3 = 3'h5
  } fps_cmd_t;

  // embedded algorithm
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_PROG = 3'h1,
    OP_WIN = 3'h3,
    OP_ERASE = 3'h2,
    OP_PROT = 3'h6,
    OP_FAIL = 3'h7
  } fps_op_t;

endpackage

// file: verilog/fps_lane_steer.sv
// byte-lane write steering for 8-bit and 16-bit bus modes
module fps_lane_steer (
  // bus side
  input wire logic bus_mode16,
  input wire logic [1:0] lane_mode,
  input wire logic addr_a0,
  input wire logic [15:0] wdata,
  input wire logic high_byte_enable_n,
  input wire logic low_lane_write_n,
  input wire logic high_lane_write_n,
  // lane enables and data
  output logic we_even,
  output logic we_odd,
  output logic [7:0] even_data,
  output logic [7:0] odd_data
);

  // ==========================================================
  // lane selection per mode
  always_comb begin
    we_even = 1'b0;
    we_odd = 1'b0;
    even_data = wdata[7:0];
    odd_data = wdata[15:8];
    if (!bus_mode16) begin
      // single bytes, even or odd, always on the low lines
      we_even = !addr_a0;
      we_odd = addr_a0;
      odd_data = wdata[7:0];
    end else begin
      unique case (lane_mode)
        fps_pkg::LANE_BHE: begin
          we_even = !addr_a0;
          we_odd = !high_byte_enable_n;
        end
        fps_pkg::LANE_SPLIT: begin
          we_even = !low_lane_write_n;
          we_odd = !high_lane_write_n;
        end
        default: begin
          we_even = 1'b1; // whole word at even address
          we_odd = 1'b1;
        end
      endcase
    end
  end

endmodule

// file: verilog/fps_flash_seq.sv
// flash command decoder, embedded program/erase algorithm and status reads
// Overview of operation
// - toggle bit inverts each busy read
// - after completion reads return array data
// - status valid after 4th/6th write
// - program into protected sector ignored
// - all protected erase: toggle low, window
// - error bit zero normally, one on fail
// - error on 0-to-1 attempt or timeout
// - reset command clears error bit; starting a program or erase also clears it
// - erase window bit low during window
// - bytes in 8-bit, words in 16-bit
// - high-byte enable with A0 steers lanes
// - split strobes steer byte lanes
// - lanes affect writes; reads whole words
// - programming only clears bits
// - erase by sector or bulk only
// - poll, toggle and ready/busy report done
// - poll bit complements written bit 7
// - erase: poll reads 0, error on timeout
// - bad word or gap returns to read
module fps_flash_seq #(
  parameter int NUM_SECT = 8,
  parameter int SECT_AW = 8,
  parameter int ERASE_WINDOW_CYC =
    (fps_pkg::ERASE_WINDOW_NS + fps_pkg::CLK_PERIOD_NS - 1) / fps_pkg::CLK_PERIOD_NS,
  parameter int CMD_GAP_CYC = fps_pkg::CMD_GAP_NS / fps_pkg::CLK_PERIOD_NS,
  parameter int ERASE_LIMIT_CYC = fps_pkg::ERASE_LIMIT_NS / fps_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // host bus, strobes are one-cycle pulses
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [NUM_SECT-1:0] main_sector_selects,
  // bus configuration and lane controls
  input wire logic bus_mode16,
  input wire logic [1:0] lane_mode,
  input wire logic high_byte_enable_n,
  input wire logic low_lane_write_n,
  input wire logic high_lane_write_n,
  // array condition
  input wire logic [NUM_SECT-1:0] sector_protect,
  input wire logic cell_fail,
  // read answer and status
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic ready_busy_pin
);

  localparam int SIDX_W = (NUM_SECT > 1) ? $clog2(NUM_SECT) : 1;
  localparam int MEM_AW = SIDX_W + SECT_AW;
  localparam int CW = fps_pkg::CNT_W;
  localparam logic [CW-1:0] PROG_LAST =
    CW'((fps_pkg::PROG_TIME_NS + fps_pkg::CLK_PERIOD_NS - 1) / fps_pkg::CLK_PERIOD_NS - 1);
  localparam logic [CW-1:0] PROG_LIMIT_LAST =
    CW'(fps_pkg::PROG_LIMIT_NS / fps_pkg::CLK_PERIOD_NS - 1);
  localparam logic [CW-1:0] WIN_LAST = CW'(ERASE_WINDOW_CYC - 1);
  localparam logic [CW-1:0] GAP_LAST = CW'(CMD_GAP_CYC - 1);
  localparam logic [CW-1:0] ERASE_LIMIT_LAST = CW'(ERASE_LIMIT_CYC - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [MEM_AW-1:0] IDX_LAST = '1;
  localparam logic [MEM_AW-1:0] IDX_ONE = MEM_AW'(1);

  // ==========================================================
  // state
  fps_pkg::fps_cmd_t cmd_state;
  fps_pkg::fps_op_t op_state;
  logic [7:0] mem [0:(1 << MEM_AW) - 1];
  logic [CW-1:0] gap_count;
  logic [CW-1:0] op_count;
  logic [MEM_AW-1:0] er_idx;
  logic [NUM_SECT-1:0] erase_mask;
  logic [MEM_AW-1:0] pg_base;
  logic pg_we_even;
  logic pg_we_odd;
  logic [7:0] pg_even;
  logic [7:0] pg_odd;
  logic pg_poll;
  logic last_was_erase;
  logic fail_flag;
  logic toggle_bit;
  logic window_bit;

  // ==========================================================
  // address decode
  logic sel_any;
  logic [SIDX_W-1:0] sect_idx;
  logic [MEM_AW-1:0] base_idx;
  logic [7:0] cmd_d;
  logic [11:0] cmd_a;
  logic [11:0] addr_u1;
  logic [11:0] addr_u2;

  // one-hot select to sector number
  always_comb begin
    sect_idx = '0;
    for (int i = 0; i < NUM_SECT; i++) begin
      if (main_sector_selects[i]) begin
        sect_idx = SIDX_W'(i);
      end
    end
  end

  assign sel_any = |main_sector_selects;
  assign base_idx = {sect_idx, bus_addr[SECT_AW-1:1], 1'b0};
  assign cmd_d = bus_wdata[7:0];
  assign cmd_a = bus_addr[fps_pkg::CMD_ADDR_W-1:0];
  assign addr_u1 = bus_mode16 ? fps_pkg::ADDR16_UNLOCK1 : fps_pkg::ADDR8_UNLOCK1;
  assign addr_u2 = bus_mode16 ? fps_pkg::ADDR16_UNLOCK2 : fps_pkg::ADDR8_UNLOCK2;

  // ==========================================================
  // lane steering
  logic we_even;
  logic we_odd;
  logic [7:0] even_data;
  logic [7:0] odd_data;

  fps_lane_steer u_lane (
    .bus_mode16(bus_mode16),
    .lane_mode(lane_mode),
    .addr_a0(bus_addr[0]),
    .wdata(bus_wdata),
    .high_byte_enable_n(high_byte_enable_n),
    .low_lane_write_n(low_lane_write_n),
    .high_lane_write_n(high_lane_write_n),
    .we_even(we_even),
    .we_odd(we_odd),
    .even_data(even_data),
    .odd_data(odd_data)
  );

  // ==========================================================
  // events
  logic wr_ok;
  logic dec_open;
  logic reset_cmd;
  logic start_prog;
  logic start_sect;
  logic start_bulk;
  logic prog_viol;
  logic prog_end;
  logic prog_timeout;
  logic win_done;
  logic er_step;
  logic er_timeout;
  logic busy_read;
  logic [NUM_SECT-1:0] live_mask;
  logic [NUM_SECT-1:0] sect_onehot;

  // decoder listens when idle or inside the erase window
  assign wr_ok = bus_wr && sel_any;
  assign dec_open = (op_state == fps_pkg::OP_IDLE) || (op_state == fps_pkg::OP_WIN);
  assign reset_cmd = wr_ok && (cmd_d == fps_pkg::CMD_RESET) &&
                     ((op_state == fps_pkg::OP_IDLE) || (op_state == fps_pkg::OP_FAIL));
  assign start_prog = wr_ok && (cmd_state == fps_pkg::CMD_PGM) &&
                      (op_state == fps_pkg::OP_IDLE) &&
                      !sector_protect[sect_idx];
  assign start_sect = wr_ok && dec_open && (cmd_state == fps_pkg::CMD_E3) &&
                      (cmd_d == fps_pkg::CMD_SECTOR_ERASE);
  assign start_bulk = wr_ok && (op_state == fps_pkg::OP_IDLE) &&
                      (cmd_state == fps_pkg::CMD_E3) && (cmd_d == fps_pkg::CMD_BULK_ERASE);
  assign sect_onehot = NUM_SECT'(1) << sect_idx;
  assign live_mask = erase_mask & ~sector_protect;
  // any written bit that asks to go from 0 back to 1
  assign prog_viol = (pg_we_even && |(pg_even & ~mem[pg_base])) ||
                     (pg_we_odd && |(pg_odd & ~mem[pg_base | IDX_ONE]));
  assign prog_end = (op_state == fps_pkg::OP_PROG) && (op_count >= PROG_LAST) && !cell_fail;
  assign prog_timeout = (op_state == fps_pkg::OP_PROG) && (op_count == PROG_LIMIT_LAST);
  assign win_done = (op_state == fps_pkg::OP_WIN) && (op_count == WIN_LAST);
  assign er_step = (op_state == fps_pkg::OP_ERASE) && !cell_fail;
  assign er_timeout = (op_state == fps_pkg::OP_ERASE) && (op_count == ERASE_LIMIT_LAST);
  assign busy_read = bus_rd && sel_any && (op_state != fps_pkg::OP_IDLE);

  // ==========================================================
  // command decoder
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_state <= fps_pkg::CMD_IDLE;
    end else if (wr_ok && dec_open) begin
      if (cmd_d == fps_pkg::CMD_RESET) begin
        cmd_state <= fps_pkg::CMD_IDLE;
      end else begin
        unique case (cmd_state)
          fps_pkg::CMD_IDLE, fps_pkg::CMD_E1: begin
            if (cmd_d == fps_pkg::CMD_UNLOCK1 && cmd_a == addr_u1) begin
              cmd_state <= (cmd_state == fps_pkg::CMD_IDLE) ? fps_pkg::CMD_U1
                                                            : fps_pkg::CMD_E2;
            end else begin
              cmd_state <= fps_pkg::CMD_IDLE;
            end
          end
          fps_pkg::CMD_U1, fps_pkg::CMD_E2: begin
            if (cmd_d == fps_pkg::CMD_UNLOCK2 && cmd_a == addr_u2) begin
              cmd_state <= (cmd_state == fps_pkg::CMD_U1) ? fps_pkg::CMD_U2
                                                          : fps_pkg::CMD_E3;
            end else begin
              cmd_state <= fps_pkg::CMD_IDLE;
            end
          end
          fps_pkg::CMD_U2: begin
            if (cmd_a == addr_u1 && cmd_d == fps_pkg::CMD_PROGRAM) begin
              cmd_state <= fps_pkg::CMD_PGM;
            end else if (cmd_a == addr_u1 && cmd_d == fps_pkg::CMD_ERASE_SETUP) begin
              cmd_state <= fps_pkg::CMD_E1;
            end else begin
              cmd_state <= fps_pkg::CMD_IDLE;
            end
          end
          default: begin
            cmd_state <= fps_pkg::CMD_IDLE; // data write or final erase word
          end
        endcase
      end
    end else if (cmd_state != fps_pkg::CMD_IDLE && gap_count == GAP_LAST) begin
      cmd_state <= fps_pkg::CMD_IDLE;
    end
  end

  // gap timer between command writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst || wr_ok || cmd_state == fps_pkg::CMD_IDLE) begin
      gap_count <= '0;
    end else begin
      gap_count <= gap_count + CNT_ONE;
    end
  end

  // ==========================================================
  // embedded algorithm sequencer and its cycle counter
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_state <= fps_pkg::OP_IDLE;
      op_count <= '0;
    end else begin
      op_count <= op_count + CNT_ONE;
      unique case (op_state)
        fps_pkg::OP_IDLE: begin
          op_count <= '0;
          if (start_prog) begin
            op_state <= fps_pkg::OP_PROG;
          end else if (start_sect) begin
            op_state <= fps_pkg::OP_WIN;
          end else if (start_bulk) begin
            // bulk erase skips the window
            op_state <= (&sector_protect) ? fps_pkg::OP_PROT : fps_pkg::OP_ERASE;
          end
        end
        fps_pkg::OP_PROG: begin
          if (prog_end) begin
            op_state <= prog_viol ? fps_pkg::OP_FAIL : fps_pkg::OP_IDLE;
          end else if (prog_timeout) begin
            op_state <= fps_pkg::OP_FAIL;
          end
        end
        fps_pkg::OP_WIN: begin
          if (start_sect) begin
            op_count <= '0; // another sector restarts the window
          end else if (win_done) begin
            op_count <= '0;
            op_state <= (live_mask == '0) ? fps_pkg::OP_PROT : fps_pkg::OP_ERASE;
          end
        end
        fps_pkg::OP_ERASE: begin
          if (er_step && er_idx == IDX_LAST) begin
            op_state <= fps_pkg::OP_IDLE;
          end else if (er_timeout) begin
            op_state <= fps_pkg::OP_FAIL;
          end
        end
        fps_pkg::OP_PROT: begin
          if (op_count == WIN_LAST) begin
            op_state <= fps_pkg::OP_IDLE;
          end
        end
        fps_pkg::OP_FAIL: begin
          if (reset_cmd) begin
            op_state <= fps_pkg::OP_IDLE;
          end
        end
        default: begin
          op_state <= fps_pkg::OP_IDLE;
        end
      endcase
    end
  end

  // program target and erase selection latches
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pg_base <= '0;
      pg_we_even <= 1'b0;
      pg_we_odd <= 1'b0;
      pg_even <= '0;
      pg_odd <= '0;
      pg_poll <= 1'b0;
      erase_mask <= '0;
      last_was_erase <= 1'b0;
    end else begin
      if (start_prog) begin
        pg_base <= base_idx;
        pg_we_even <= we_even;
        pg_we_odd <= we_odd;
        pg_even <= even_data;
        pg_odd <= odd_data;
        pg_poll <= we_even ? even_data[7] : odd_data[7];
        last_was_erase <= 1'b0;
      end
      if (start_sect) begin
        erase_mask <= (op_state == fps_pkg::OP_WIN) ? (erase_mask | sect_onehot)
                                                    : sect_onehot;
        last_was_erase <= 1'b1;
      end else if (start_bulk) begin
        erase_mask <= '1;
        last_was_erase <= 1'b1;
      end
    end
  end

  // erase sweep address, one byte per cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst || op_state != fps_pkg::OP_ERASE) begin
      er_idx <= '0;
    end else if (er_step) begin
      er_idx <= er_idx + IDX_ONE;
    end
  end

  // ==========================================================
  // array: programming only clears bits, erase sets whole sectors
  always_ff @(posedge ref_clk) begin
    if (prog_end) begin
      if (pg_we_even) begin
        mem[pg_base] <= mem[pg_base] & pg_even;
      end
      if (pg_we_odd) begin
        mem[pg_base | IDX_ONE] <= mem[pg_base | IDX_ONE] & pg_odd;
      end
    end
    if (er_step && live_mask[er_idx[MEM_AW-1:SECT_AW]]) begin
      mem[er_idx] <= fps_pkg::ERASED_BYTE; // protected sectors skipped
    end
  end

  // ==========================================================
  // status flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fail_flag <= 1'b0;
      toggle_bit <= 1'b0;
      window_bit <= 1'b1;
    end else begin
      // failure wins over a clear in the same cycle
      if (reset_cmd) begin
        fail_flag <= 1'b0;
      end
      if (start_prog || start_sect || start_bulk) begin
        fail_flag <= 1'b0;
      end
      if ((prog_end && prog_viol) || prog_timeout || er_timeout) begin
        fail_flag <= 1'b1;
      end
      if (op_state == fps_pkg::OP_PROT) begin
        toggle_bit <= 1'b0;
      end else if (busy_read) begin
        toggle_bit <= !toggle_bit;
      end
      if (start_sect) begin
        window_bit <= 1'b0;
      end else if (win_done || start_bulk) begin
        window_bit <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read answer, one cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= bus_rd && sel_any;
      if (busy_read) begin
        rd_data <= fps_pkg::STATUS_ZERO;
        // program shows complemented bit 7, erase and protect show 0
        rd_data[fps_pkg::POLL_POS] <= !last_was_erase &&
          ((op_state == fps_pkg::OP_PROG) || (op_state == fps_pkg::OP_FAIL)) &&
          !pg_poll;
        rd_data[fps_pkg::TOGGLE_POS] <= (op_state != fps_pkg::OP_PROT) && !toggle_bit;
        rd_data[fps_pkg::FAIL_POS] <= fail_flag;
        rd_data[fps_pkg::WINDOW_POS] <= window_bit;
      end else if (bus_rd && sel_any) begin
        if (bus_mode16) begin
          rd_data <= {mem[base_idx | IDX_ONE], mem[base_idx]};
        end else begin
          rd_data <= {8'h00, mem[{sect_idx, bus_addr[SECT_AW-1:0]}]};
        end
      end
    end
  end

  // ready/busy pin, high when no algorithm runs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ready_busy_pin <= 1'b1;
    end else begin
      ready_busy_pin <= (op_state == fps_pkg::OP_IDLE) && !start_prog && !start_sect &&
                        !start_bulk;
    end
  end

endmodule

// file: dv/fps_flash_seq_monitor.sv
// port assertions for the flash sequencer
module fps_flash_seq_monitor #(
  parameter int NUM_SECT = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // host bus
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [NUM_SECT-1:0] main_sector_selects,
  input wire logic bus_mode16,
  // answer
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic ready_busy_pin
);
  // ====================
  // read strobe that meets a select
  logic taken;
  assign taken = bus_rd && (|main_sector_selects);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // ====================
  // read answer timing
  answer_once_a: assert property (taken |=> rd_valid)
    else $error("taken read not answered");
  answer_cause_a: assert property (rd_valid |-> $past(taken))
    else $error("answer without a taken read");
  data_hold_a: assert property (!taken |=> $stable(rd_data))
    else $error("read data moved without a read");
  // status word shape while the algorithm runs
  status_form_a: assert property (taken && !ready_busy_pin ##1 !ready_busy_pin
    |-> rd_data[15:8] == 8'h00 && rd_data[4] == 1'b0 && rd_data[2:0] == 3'h0)
    else $error("status word has stray bits");
  busy_start_a: assert property ($fell(ready_busy_pin) |-> $past(bus_wr))
    else $error("busy without a write");
  fail_hold_a: assert property (rd_valid && rd_data[5] && !ready_busy_pin
    |=> !ready_busy_pin || $past(bus_wr) || $past(bus_wr, 2))
    else $error("fail state left without a write");
  byte_upper_a: assert property (taken && !bus_mode16 |=> rd_data[15:8] == 8'h00)
    else $error("byte mode read has upper byte");
  busy_min_a: assert property ($rose(ready_busy_pin)
    |-> $past(ready_busy_pin, 8) == 1'b0)
    else $error("busy pulse too short");
endmodule

bind fps_flash_seq fps_flash_seq_monitor #(.NUM_SECT(NUM_SECT)) mon_u (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .bus_wr(bus_wr),
  .bus_rd(bus_rd),
  .main_sector_selects(main_sector_selects),
  .bus_mode16(bus_mode16),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .ready_busy_pin(ready_busy_pin)
);

// file: dv/fps_host_model.sv
// host bus model with one-cycle strobes
module fps_host_model (
  // clock
  input wire logic ref_clk,
  // bus
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  // answer
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // one write; released lines show the inverse
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk) #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge ref_clk) #1;
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask
  // one read, callers keep status reads even in word mode
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk) #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge ref_clk) #1;
    bus_rd = 1'b0;
    bus_addr = ~a;
    d = rd_valid ? rd_data : 16'hxxxx;
  endtask
  // read until two reads match, then keep the readback
  task automatic settle(input logic [15:0] a, output logic [15:0] d);
    logic [15:0] p;
    int n;
    rd(a, p);
    rd(a, d);
    n = 0;
    while (d !== p && n < 400) begin
      p = d;
      rd(a, d);
      n++;
    end
  endtask
endmodule

// file: dv/fps_flash_seq_tb_top.sv
// self-checking bench for the flash sequencer
module fps_flash_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  logic ref_clk, sys_rst, bus_wr, bus_rd, rd_valid, rdy;
  logic m16, hbe_n, wl_n, wh_n, cell_fail;
  logic [15:0] bus_addr, bus_wdata, rd_data;
  logic [1:0] lm;
  logic [7:0] sel, prot;
  int mismatches, check_count;
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  fps_flash_seq #(.ERASE_WINDOW_CYC(20), .CMD_GAP_CYC(50), .ERASE_LIMIT_CYC(4000)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .main_sector_selects(sel), .bus_mode16(m16),
    .lane_mode(lm), .high_byte_enable_n(hbe_n), .low_lane_write_n(wl_n),
    .high_lane_write_n(wh_n), .sector_protect(prot), .cell_fail(cell_fail),
    .rd_data(rd_data), .rd_valid(rd_valid), .ready_busy_pin(rdy));
  fps_host_model h_u (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .rd_data(rd_data), .rd_valid(rd_valid));
  // ====================
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  // coded cycles then one command word
  task automatic unlock(input logic [7:0] cmd);
    logic [15:0] u1, u2;
    u1 = m16 ? 16'(fps_pkg::ADDR16_UNLOCK1) : 16'(fps_pkg::ADDR8_UNLOCK1);
    u2 = m16 ? 16'(fps_pkg::ADDR16_UNLOCK2) : 16'(fps_pkg::ADDR8_UNLOCK2);
    h_u.wr(u1, 16'(fps_pkg::CMD_UNLOCK1));
    h_u.wr(u2, 16'(fps_pkg::CMD_UNLOCK2));
    h_u.wr(u1, {8'h00, cmd});
  endtask
  task automatic prog(input logic [15:0] a, input logic [15:0] d);
    unlock(fps_pkg::CMD_PROGRAM);
    h_u.wr(a, d);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 6000) begin
      @(posedge ref_clk) #1;
      n++;
    end
    chk({15'h0000, rdy}, 16'h0001);
    @(posedge ref_clk) #1;
  endtask
  // ====================
  task automatic t_erase();
    logic [15:0] a, b;
    unlock(fps_pkg::CMD_ERASE_SETUP);
    unlock(fps_pkg::CMD_BULK_ERASE);
    h_u.rd(16'h0000, a);
    h_u.rd(16'h0000, b);
    chk(a & 16'hffbf, 16'h0008);
    chk(a ^ b, 16'h0040);
    wait_rdy();
    h_u.rd(16'h0010, a);
    chk(a, 16'hffff);
    $display("bulk erase test done");
  endtask
  task automatic t_prog();
    logic [15:0] a, b;
    prog(16'h0010, 16'h1234);
    h_u.rd(16'h0010, a);
    h_u.rd(16'h0010, b);
    chk(a & 16'hffbf, 16'h0088);
    chk(a ^ b, 16'h0040);
    h_u.settle(16'h0010, a);
    chk(a, 16'h1234);
    $display("word program test done");
  endtask
  task automatic lane(input logic [4:0] cfg, input logic [15:0] a, d, e);
    logic [15:0] r;
    {lm, hbe_n, wl_n, wh_n} = cfg;
    prog(a, d);
    wait_rdy();
    h_u.rd(a, r);
    chk(r, e);
  endtask
  task automatic t_lanes();
    lane({2'h1, 3'b111}, 16'h0020, 16'hab56, 16'hff56);
    lane({2'h1, 3'b011}, 16'h0031, 16'h9a77, 16'h9aff);
    lane({2'h2, 3'b110}, 16'h0040, 16'h78cd, 16'h78ff);
    lane({2'h2, 3'b101}, 16'h0050, 16'h78cd, 16'hffcd);
    {lm, hbe_n, wl_n, wh_n} = 5'h07;
    $display("byte lane test done");
  endtask
  task automatic t_fail();
    logic [15:0] a, b;
    prog(16'h0010, 16'hffff);
    repeat (250) @(posedge ref_clk);
    h_u.rd(16'h0010, a);
    chk(a & 16'hff20, 16'h0020);
    chk({15'h0000, rdy}, 16'h0000);
    h_u.wr(16'h0010, 16'h0030);
    h_u.rd(16'h0010, a);
    chk(a & 16'hff20, 16'h0020);
    h_u.wr(16'h0000, 16'(fps_pkg::CMD_RESET));
    wait_rdy();
    h_u.rd(16'h0010, a);
    chk(a, 16'h1234);
    // stalled cells: program, then bulk erase, run into their internal limits
    cell_fail = 1'b1;
    prog(16'h0070, 16'h0000);
    repeat (2010) @(posedge ref_clk);
    h_u.rd(16'h0070, a);
    h_u.rd(16'h0070, b); // poll bit read once more after the error
    chk(a & 16'hffa0, 16'h00a0);
    chk(b & 16'hffa0, 16'h00a0);
    h_u.wr(16'h0000, 16'(fps_pkg::CMD_RESET));
    unlock(fps_pkg::CMD_ERASE_SETUP);
    unlock(fps_pkg::CMD_BULK_ERASE);
    repeat (4010) @(posedge ref_clk);
    h_u.rd(16'h0070, a);
    chk(a & 16'hffa0, 16'h0020);
    cell_fail = 1'b0;
    h_u.wr(16'h0000, 16'(fps_pkg::CMD_RESET));
    wait_rdy();
    h_u.rd(16'h0070, a);
    chk(a, 16'hffff);
    $display("program fail test done");
  endtask
  task automatic t_prot();
    logic [15:0] a, b;
    prot = 8'h02;
    sel = 8'h02;
    prog(16'h0010, 16'h0000);
    h_u.rd(16'h0010, a);
    chk(a, 16'hffff);
    unlock(fps_pkg::CMD_ERASE_SETUP);
    unlock(fps_pkg::CMD_SECTOR_ERASE);
    h_u.rd(16'h0010, a);
    h_u.rd(16'h0010, b);
    chk((a | b) & 16'hffbf, 16'h0000);
    // past the window: toggle held low, window bit back to one
    repeat (20) @(posedge ref_clk);
    h_u.rd(16'h0010, a);
    h_u.rd(16'h0010, b);
    chk(a | b, 16'h0008);
    wait_rdy();
    h_u.rd(16'h0010, a);
    chk(a, 16'hffff);
    prot = 8'h00;
    sel = 8'h01;
    $display("protection test done");
  endtask
  task automatic t_byte8();
    logic [15:0] a;
    m16 = 1'b0;
    prog(16'h0061, 16'h005a);
    wait_rdy();
    h_u.rd(16'h0061, a);
    chk(a, 16'h005a);
    h_u.rd(16'h0060, a);
    chk(a, 16'h00ff);
    h_u.wr(16'(fps_pkg::ADDR8_UNLOCK1), 16'h00aa);
    repeat (60) @(posedge ref_clk);
    h_u.wr(16'(fps_pkg::ADDR8_UNLOCK2), 16'h0055);
    h_u.wr(16'(fps_pkg::ADDR8_UNLOCK1), 16'h00a0);
    h_u.wr(16'h0062, 16'h0000);
    h_u.rd(16'h0062, a);
    chk(a, 16'h00ff);
    $display("byte mode test done");
  endtask
  // ====================
  // reset, then the scenarios in order
  initial begin
    sys_rst = 1'b1;
    m16 = 1'b1;
    sel = 8'h01;
    prot = 8'h00;
    cell_fail = 1'b0;
    {lm, hbe_n, wl_n, wh_n} = 5'h07;
    mismatches = 0;
    check_count = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_erase();
    t_prog();
    t_lanes();
    t_fail();
    t_prot();
    t_byte8();
    end_of_test();
  end
  // watchdog, about five times the expected run
  initial begin
    #500000;
    mismatches++;
    end_of_test();
  end
endmodule
